// ---- array_model.sv ----
// behavioural flash and eeprom arrays answering each start with a done pulse when latency_in is two or more
module array_model (
    // clock and reset
    input  wire logic       clock_in,
    input  wire logic       rst_in,
    // handshake with the controller
    input  wire logic       flash_start_in,
    input  wire logic       eeprom_start_in,
    input  wire logic [7:0] latency_in,
    output logic            flash_done_out,
    output logic            eeprom_done_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] f_cnt_reg;
    logic [7:0] e_cnt_reg;
    // zero means idle; latency below two gives no done at all, so keep it above one
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            f_cnt_reg <= 8'h00;
            e_cnt_reg <= 8'h00;
            flash_done_out <= 1'b0;
            eeprom_done_out <= 1'b0;
        end else begin
            f_cnt_reg <= flash_start_in ? latency_in : (f_cnt_reg != 8'h00 ? f_cnt_reg - 8'h01 : 8'h00);
            e_cnt_reg <= eeprom_start_in ? latency_in : (e_cnt_reg != 8'h00 ? e_cnt_reg - 8'h01 : 8'h00);
            flash_done_out <= f_cnt_reg == 8'h02;
            eeprom_done_out <= e_cnt_reg == 8'h02;
        end
    end
endmodule

// ---- nvm_command_controller.sv ----
// command, protection, status and sleep logic of the memory controller
module nvm_command_controller #(
    parameter logic [15:0] EEPROM_BASE = 16'h1400,
    parameter logic [15:0] EEPROM_END  = 16'h1480,
    parameter logic [15:0] APP_BASE    = 16'h8200,
    parameter logic [15:0] APP_END     = 16'h9000
) (
    // clock and reset
    input  wire logic        clock_in,
    input  wire logic        sys_rst_in,
    // avalon-mm slave
    input  wire logic [5:0]  address_in,
    input  wire logic        read_in,
    input  wire logic        write_in,
    input  wire logic [31:0] writedata_in,
    input  wire logic [3:0]  byteenable_in,
    output logic      [31:0] readdata_out,
    output logic             waitrequest_out,
    // access origin and key unlock
    input  wire logic        debug_access_in,
    input  wire logic        self_program_key_in,
    input  wire logic        instr_retired_in,
    input  wire logic        exec_in_boot_in,
    // page buffer loads
    input  wire logic        buffer_load_in,
    input  wire logic [15:0] buffer_load_addr_in,
    // memory arrays
    output logic             flash_start_out,
    output logic             eeprom_start_out,
    output logic [2:0]       array_cmd_out,
    output logic [15:0]      array_addr_out,
    output logic [15:0]      fuse_data_out,
    input  wire logic        flash_done_in,
    input  wire logic        eeprom_done_in,
    output logic             page_buffer_clear_out,
    input  wire logic        eeprom_preserve_fuse_in,
    // boot section read path
    input  wire logic        mem_boot_access_in,
    input  wire logic [15:0] mem_rdata_in,
    output logic      [15:0] mem_rdata_out,
    output logic             boot_lock_active_out,
    // cpu and system
    output logic             cpu_halt_out,
    input  wire logic        sleep_req_in,
    input  wire logic [1:0]  sleep_mode_in,
    output logic             nvm_sleep_out,
    output logic             keep_clock_out,
    output logic             irq_out,
    output logic             wake_out
);

    logic                ack_reg;
    logic [31:0]         rdata_reg;
    logic [2:0]          cmd_reg;
    logic                app_wp_reg;
    logic                boot_lock_reg;
    logic                boot_eff_reg;
    logic                exec_boot_d_reg;
    logic                flash_busy_reg;
    logic                ee_busy_reg;
    logic                wr_err_reg;
    logic                irq_en_reg;
    logic                ee_ready_reg;
    logic [15:0]         data_reg;
    logic [15:0]         addr_reg;
    logic [2:0]          key_cnt_reg;
    nvm_pkg::seq_state_e state_reg;
    logic [2:0]          clr_cnt_reg;
    logic                page_op_reg;
    logic                eeprom_erase_cmd_reg;
    logic                loaded_reg;
    logic                load_sec_ee_reg;
    logic                mixed_reg;
    logic                sleep_d_reg;
    logic                buf_clr_reg;
    logic                flash_start_reg;
    logic                ee_start_reg;
    logic [2:0]          array_cmd_reg;
    logic [15:0]         mem_rdata_reg;

    // bus decode; every access answers on its second cycle
    wire [3:0] reg_idx = address_in[5:2];
    wire       bus_req = read_in | write_in;
    wire       wr_fire = write_in & ack_reg;
    wire       rd_load = read_in & ~ack_reg;
    wire       lane0   = byteenable_in[0];
    wire       lane1   = byteenable_in[1];
    wire       wr_cmd  = wr_fire & lane0 & (reg_idx == nvm_pkg::IDX_CMD);
    wire       wr_prot = wr_fire & lane0 & (reg_idx == nvm_pkg::IDX_PROT);
    wire       wr_ien  = wr_fire & lane0 & (reg_idx == nvm_pkg::IDX_IRQ_EN);
    wire       wr_flg  = wr_fire & lane0 & (reg_idx == nvm_pkg::IDX_IRQ_FLAGS);
    wire       wr_dlo  = wr_fire & (reg_idx == nvm_pkg::IDX_DATA_LO);
    wire       wr_dhi  = wr_fire & lane0 & (reg_idx == nvm_pkg::IDX_DATA_HI);
    wire       wr_alo  = wr_fire & (reg_idx == nvm_pkg::IDX_ADDR_LO);
    wire       wr_ahi  = wr_fire & lane0 & (reg_idx == nvm_pkg::IDX_ADDR_HI);

    // command acceptance
    wire nvm_pkg::nvm_cmd_e cmd_val = nvm_pkg::nvm_cmd_e'(writedata_in[nvm_pkg::CMD_W-1:0]);
    wire key_open   = (key_cnt_reg != 3'h0) | debug_access_in;
    wire any_busy   = flash_busy_reg | ee_busy_reg | (state_reg == nvm_pkg::ST_CLEAR);
    wire fuse_deny  = (cmd_val == nvm_pkg::CMD_FUSE_WRITE) & ~debug_access_in;
    wire cmd_go     = wr_cmd & key_open & ~any_busy & ~fuse_deny
                      & (cmd_val != nvm_pkg::CMD_NONE);
    wire is_page_op = (cmd_val == nvm_pkg::CMD_PAGE_WRITE) | (cmd_val == nvm_pkg::CMD_PAGE_ERASE)
                      | (cmd_val == nvm_pkg::CMD_ERASE_WRITE);
    wire is_chip_erase_cmd    = cmd_val == nvm_pkg::CMD_CHIP_ERASE;
    wire is_eeprom_erase_cmd    = cmd_val == nvm_pkg::CMD_EEPROM_ERASE;
    wire is_wfu     = cmd_val == nvm_pkg::CMD_FUSE_WRITE;
    wire is_pbc     = cmd_val == nvm_pkg::CMD_BUFFER_CLEAR;

    // target selection from the address register and from the buffer load address
    wire target_ee  = (addr_reg >= EEPROM_BASE) & (addr_reg < EEPROM_END);
    wire target_app = (addr_reg >= APP_BASE) & (addr_reg < APP_END);
    wire load_ee    = (buffer_load_addr_in >= EEPROM_BASE) & (buffer_load_addr_in < EEPROM_END);

    // chip erase is not subject to the section protection
    wire err_cause  = is_page_op & (mixed_reg | (~target_ee & target_app & app_wp_reg));
    wire launch     = cmd_go & ~err_cause & ~is_pbc;
    wire flash_go   = launch & ((is_page_op & ~target_ee) | is_chip_erase_cmd | is_wfu);
    wire ee_go      = launch & ((is_page_op & target_ee) | is_eeprom_erase_cmd
                      | (is_chip_erase_cmd & ~eeprom_preserve_fuse_in));

    // completion of page operations releases the buffer
    wire flash_fin  = flash_busy_reg & flash_done_in;
    wire ee_fin     = ee_busy_reg & eeprom_done_in;
    wire page_fin   = page_op_reg & (flash_fin | ee_fin);
    wire clr_last   = (state_reg == nvm_pkg::ST_CLEAR) & (clr_cnt_reg == 3'h1);
    wire wake_edge  = sleep_d_reg & ~sleep_req_in;
    wire buf_clr_next = page_fin | clr_last | wake_edge;

    // key window counts retired instructions
    wire [2:0] key_cnt_dec  = (key_cnt_reg != 3'h0) ? key_cnt_reg - 3'h1 : 3'h0;
    wire [2:0] key_cnt_next = self_program_key_in ? nvm_pkg::KEY_WINDOW_INSTR :
                              wr_cmd              ? 3'h0 :
                              instr_retired_in    ? key_cnt_dec : key_cnt_reg;

    // busy flags: start wins over done
    wire flash_busy_next = flash_go | (flash_busy_reg & ~flash_done_in);
    wire ee_busy_next    = ee_go | (ee_busy_reg & ~eeprom_done_in);

    // ready flag is re-set every idle cycle, so a clear only sticks while busy
    wire ee_ready_next   = ~ee_busy_reg | (ee_ready_reg & ~(wr_flg & writedata_in[nvm_pkg::IRQ_EEPROM_READY_BIT]));

    // boot lock is armed from boot code and bites on the first exit
    wire boot_lock_set   = wr_prot & writedata_in[nvm_pkg::PROT_BOOT_LOCK_BIT] & exec_in_boot_in;
    wire boot_eff_next   = boot_eff_reg | (boot_lock_reg & exec_boot_d_reg & ~exec_in_boot_in);
    wire app_wp_next     = app_wp_reg | (wr_prot & writedata_in[nvm_pkg::PROT_APP_WP_BIT]);

    // mixed-section tracking across buffer loads
    wire mixed_next = buf_clr_reg ? 1'b0 :
                      (mixed_reg | (buffer_load_in & loaded_reg & (load_ee != load_sec_ee_reg)));
    wire loaded_next = buf_clr_reg ? 1'b0 : (loaded_reg | buffer_load_in);
    wire load_sec_next = (buffer_load_in & ~loaded_reg) ? load_ee : load_sec_ee_reg;

    // data and address registers, byte-wide halves
    wire [15:0] data_next = {wr_dhi ? writedata_in[7:0] : (wr_dlo & lane1) ? writedata_in[15:8] : data_reg[15:8],
                             (wr_dlo & lane0) ? writedata_in[7:0] : data_reg[7:0]};
    wire [15:0] addr_bus  = {wr_ahi ? writedata_in[7:0] : (wr_alo & lane1) ? writedata_in[15:8] : addr_reg[15:8],
                             (wr_alo & lane0) ? writedata_in[7:0] : addr_reg[7:0]};
    // a buffer load is the most recent update, so it wins over the bus
    wire [15:0] addr_next = buffer_load_in ? buffer_load_addr_in : addr_bus;

    // sequencer for the timed buffer clear
    wire nvm_pkg::seq_state_e state_next = (cmd_go & is_pbc) ? nvm_pkg::ST_CLEAR :
                                           clr_last ? nvm_pkg::ST_IDLE : state_reg;
    wire [2:0] clr_cnt_next = (cmd_go & is_pbc) ? nvm_pkg::BUFFER_CLEAR_CYCLES :
                              (state_reg == nvm_pkg::ST_CLEAR) ? clr_cnt_reg - 3'h1 : 3'h0;

    // read mux; reserved bits and unmapped words read zero
    wire [7:0] status_byte = {5'h00, wr_err_reg, ee_busy_reg, flash_busy_reg};
    wire [31:0] rd_word =
        (reg_idx == nvm_pkg::IDX_CMD)       ? {29'h0, cmd_reg} :
        (reg_idx == nvm_pkg::IDX_PROT)      ? {30'h0, boot_lock_reg, app_wp_reg} :
        (reg_idx == nvm_pkg::IDX_STATUS)    ? {24'h0, status_byte} :
        (reg_idx == nvm_pkg::IDX_IRQ_EN)    ? {31'h0, irq_en_reg} :
        (reg_idx == nvm_pkg::IDX_IRQ_FLAGS) ? {31'h0, ee_ready_reg} :
        (reg_idx == nvm_pkg::IDX_DATA_LO)   ? {16'h0, data_reg} :
        (reg_idx == nvm_pkg::IDX_DATA_HI)   ? {24'h0, data_reg[15:8]} :
        (reg_idx == nvm_pkg::IDX_ADDR_LO)   ? {16'h0, addr_reg} :
        (reg_idx == nvm_pkg::IDX_ADDR_HI)   ? {24'h0, addr_reg[15:8]} : 32'h0000_0000;

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= bus_req & ~ack_reg;
            if (rd_load) begin
                rdata_reg <= rd_word;
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            cmd_reg     <= 3'h0;
            key_cnt_reg <= 3'h0;
            page_op_reg <= 1'b0;
            eeprom_erase_cmd_reg    <= 1'b0;
            wr_err_reg  <= 1'b0;
        end else begin
            key_cnt_reg <= key_cnt_next;
            if (cmd_go) begin
                cmd_reg     <= cmd_val;
                wr_err_reg  <= err_cause;
                page_op_reg <= is_page_op & ~err_cause;
                eeprom_erase_cmd_reg    <= is_eeprom_erase_cmd;
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            flash_busy_reg <= 1'b0;
            ee_busy_reg    <= 1'b0;
            ee_ready_reg   <= 1'b0;
            irq_en_reg     <= 1'b0;
        end else begin
            flash_busy_reg <= flash_busy_next;
            ee_busy_reg    <= ee_busy_next;
            ee_ready_reg   <= ee_ready_next;
            if (wr_ien) begin
                irq_en_reg <= writedata_in[nvm_pkg::IRQ_EEPROM_READY_BIT];
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            app_wp_reg      <= 1'b0;
            boot_lock_reg   <= 1'b0;
            boot_eff_reg    <= 1'b0;
            exec_boot_d_reg <= 1'b0;
        end else begin
            app_wp_reg      <= app_wp_next;
            boot_lock_reg   <= boot_lock_reg | boot_lock_set;
            boot_eff_reg    <= boot_eff_next;
            exec_boot_d_reg <= exec_in_boot_in;
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            data_reg <= nvm_pkg::RST_WORD;
            addr_reg <= nvm_pkg::RST_WORD;
        end else begin
            data_reg <= data_next;
            addr_reg <= addr_next;
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            loaded_reg      <= 1'b0;
            load_sec_ee_reg <= 1'b0;
            mixed_reg       <= 1'b0;
        end else begin
            loaded_reg      <= loaded_next;
            load_sec_ee_reg <= load_sec_next;
            mixed_reg       <= mixed_next;
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            state_reg   <= nvm_pkg::ST_IDLE;
            clr_cnt_reg <= 3'h0;
            buf_clr_reg <= 1'b0;
            sleep_d_reg <= 1'b0;
        end else begin
            state_reg   <= state_next;
            clr_cnt_reg <= clr_cnt_next;
            buf_clr_reg <= buf_clr_next;
            sleep_d_reg <= sleep_req_in;
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            flash_start_reg <= 1'b0;
            ee_start_reg    <= 1'b0;
            array_cmd_reg   <= 3'h0;
        end else begin
            flash_start_reg <= flash_go;
            ee_start_reg    <= ee_go;
            if (launch) begin
                array_cmd_reg <= cmd_val;
            end
        end
    end

    // masking adds one cycle of read latency on the array path
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            mem_rdata_reg <= nvm_pkg::RST_WORD;
        end else begin
            mem_rdata_reg <= (mem_boot_access_in & boot_eff_reg) ? 16'h0000 : mem_rdata_in;
        end
    end

    // sleep and wake control
    wire write_active = flash_busy_reg | ee_busy_reg;
    wire sleep_idle   = sleep_mode_in == nvm_pkg::SLEEP_IDLE;

    assign readdata_out          = rdata_reg;
    assign waitrequest_out       = bus_req & ~ack_reg;
    assign flash_start_out       = flash_start_reg;
    assign eeprom_start_out      = ee_start_reg;
    assign array_cmd_out         = array_cmd_reg;
    assign array_addr_out        = addr_reg;
    assign fuse_data_out         = data_reg;
    assign page_buffer_clear_out = buf_clr_reg;
    assign mem_rdata_out         = mem_rdata_reg;
    assign boot_lock_active_out  = boot_eff_reg;
    // flash work, eeprom erase and the buffer clear all hold the cpu
    assign cpu_halt_out   = flash_busy_reg | (ee_busy_reg & eeprom_erase_cmd_reg)
                            | (state_reg == nvm_pkg::ST_CLEAR);
    assign nvm_sleep_out  = sleep_req_in & ~write_active;
    assign keep_clock_out = sleep_req_in & write_active;
    assign irq_out        = irq_en_reg & ee_ready_reg;
    assign wake_out       = irq_out & sleep_req_in & sleep_idle;

endmodule

// ---- nvm_pkg.sv ----
// constants, field layout and enumerations of the memory command controller
package nvm_pkg;

    // register indices; byte address is four times the index
    localparam logic [3:0] IDX_CMD       = 4'h0;
    localparam logic [3:0] IDX_PROT      = 4'h1;
    localparam logic [3:0] IDX_STATUS    = 4'h2;
    localparam logic [3:0] IDX_IRQ_EN    = 4'h3;
    localparam logic [3:0] IDX_IRQ_FLAGS = 4'h4;
    localparam logic [3:0] IDX_DATA_LO   = 4'h6;
    localparam logic [3:0] IDX_DATA_HI   = 4'h7;
    localparam logic [3:0] IDX_ADDR_LO   = 4'h8;
    localparam logic [3:0] IDX_ADDR_HI   = 4'h9;

    // field positions
    localparam int CMD_W              = 3;
    localparam int PROT_APP_WP_BIT    = 0;
    localparam int PROT_BOOT_LOCK_BIT = 1;
    localparam int STAT_FLASH_BUSY    = 0;
    localparam int STAT_EE_BUSY       = 1;
    localparam int STAT_WR_ERR        = 2;
    localparam int IRQ_EEPROM_READY_BIT    = 0;

    // reset values
    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;

    // timing
    localparam logic [2:0] KEY_WINDOW_INSTR    = 3'h4;
    localparam logic [2:0] BUFFER_CLEAR_CYCLES = 3'h7;

    typedef enum logic [2:0] {
        CMD_NONE          = 3'h0,
        CMD_PAGE_WRITE    = 3'h1,
        CMD_PAGE_ERASE    = 3'h2,
        CMD_ERASE_WRITE   = 3'h3,
        CMD_BUFFER_CLEAR  = 3'h4,
        CMD_CHIP_ERASE    = 3'h5,
        CMD_EEPROM_ERASE  = 3'h6,
        CMD_FUSE_WRITE    = 3'h7
    } nvm_cmd_e;

    typedef enum logic [1:0] {
        SLEEP_IDLE       = 2'h0,
        SLEEP_STANDBY    = 2'h1,
        SLEEP_POWER_DOWN = 2'h2
    } sleep_mode_e;

    typedef enum logic {
        ST_IDLE  = 1'b0,
        ST_CLEAR = 1'b1
    } seq_state_e;

endpackage

// ---- nvm_props.sv ----
// concurrent checks on the memory command controller ports
module nvm_props (
    // clock and reset
    input wire logic        clock_in,
    input wire logic        sys_rst_in,
    // array handshake
    input wire logic        flash_start_out,
    input wire logic        eeprom_start_out,
    input wire logic [2:0]  array_cmd_out,
    input wire logic        flash_done_in,
    input wire logic        eeprom_done_in,
    input wire logic        page_buffer_clear_out,
    input wire logic        eeprom_preserve_fuse_in,
    input wire logic        debug_access_in,
    // boot read path
    input wire logic        exec_in_boot_in,
    input wire logic        mem_boot_access_in,
    input wire logic [15:0] mem_rdata_out,
    input wire logic        boot_lock_active_out,
    // cpu and sleep
    input wire logic        cpu_halt_out,
    input wire logic        sleep_req_in,
    input wire logic [1:0]  sleep_mode_in,
    input wire logic        nvm_sleep_out,
    input wire logic        keep_clock_out,
    input wire logic        irq_out,
    input wire logic        wake_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (sys_rst_in);
    sequence clear_run_s;
        cpu_halt_out [*7] ##1 (!cpu_halt_out && page_buffer_clear_out);
    endsequence
    sequence page_done_s;
        (flash_done_in || eeprom_done_in) && array_cmd_out inside {3'h1, 3'h2, 3'h3};
    endsequence
    buffer_clear_a:
        assert property ($rose(cpu_halt_out) && !flash_start_out && !eeprom_start_out |-> clear_run_s)
        else $error("buffer clear halt length wrong");
    page_clear_a:
        assert property (page_done_s |=> page_buffer_clear_out) else $error("no buffer clear after page op");
    wake_clear_a:
        assert property ($fell(sleep_req_in) |=> page_buffer_clear_out) else $error("no buffer clear on wake");
    wake_gate_a:
        assert property (wake_out == (irq_out && sleep_req_in && sleep_mode_in == nvm_pkg::SLEEP_IDLE))
        else $error("wake outside idle sleep");
    sleep_split_a:
        assert property (sleep_req_in |-> nvm_sleep_out != keep_clock_out) else $error("sleep and clock hold clash");
    chip_erase_a:
        assert property (flash_start_out && array_cmd_out == nvm_pkg::CMD_CHIP_ERASE
            |-> eeprom_start_out == !eeprom_preserve_fuse_in) else $error("chip erase eeprom choice wrong");
    fuse_port_a:
        assert property (flash_start_out && array_cmd_out == nvm_pkg::CMD_FUSE_WRITE |-> $past(debug_access_in))
        else $error("fuse write launched by cpu");
    boot_zero_a:
        assert property (mem_boot_access_in && boot_lock_active_out |=> mem_rdata_out == 16'h0000)
        else $error("locked boot read not zero");
    boot_sticky_a:
        assert property (boot_lock_active_out |=> boot_lock_active_out) else $error("boot lock dropped");
    boot_exit_a:
        assert property ($rose(boot_lock_active_out) |-> !$past(exec_in_boot_in)) else $error("boot lock too early");
endmodule

// ---- testbench.sv ----
// self-checking testbench of the memory command controller
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock_in, sys_rst_in, read_in, write_in, waitrequest_out, debug_access_in;
    logic        self_program_key_in, instr_retired_in, exec_in_boot_in, buffer_load_in;
    logic        flash_start_out, eeprom_start_out, flash_done_in, eeprom_done_in, page_buffer_clear_out;
    logic        eeprom_preserve_fuse_in, mem_boot_access_in, boot_lock_active_out, cpu_halt_out;
    logic        sleep_req_in, nvm_sleep_out, keep_clock_out, irq_out, wake_out;
    logic [1:0]  sleep_mode_in;
    logic [2:0]  array_cmd_out;
    logic [3:0]  byteenable_in;
    logic [5:0]  address_in;
    logic [7:0]  latency;
    logic [15:0] buffer_load_addr_in, array_addr_out, fuse_data_out, mem_rdata_in, mem_rdata_out;
    logic [31:0] writedata_in, readdata_out, rdata;
    int          n_fail, compares, n_fs, n_es;
    nvm_command_controller uut (.*);
    array_model arrays (.clock_in(clock_in), .rst_in(sys_rst_in), .flash_start_in(flash_start_out),
        .eeprom_start_in(eeprom_start_out), .latency_in(latency), .flash_done_out(flash_done_in),
        .eeprom_done_out(eeprom_done_in));
    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end
    always @(posedge clock_in) begin
        if (flash_start_out === 1'b1) n_fs++;
        if (eeprom_start_out === 1'b1) n_es++;
    end
    task automatic stop_test;
        if (n_fail == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_pin(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: pin %b expected %b", $time, got, exp);
        end
    endtask
    // request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [3:0] idx, input logic [31:0] d);
        int n;
        n = 0;
        address_in <= {idx, 2'b00};
        byteenable_in <= idx[0] ? 4'h1 : 4'h3;
        writedata_in <= d;
        write_in <= w;
        read_in <= !w;
        @(posedge clock_in);
        while (waitrequest_out !== 1'b0 && n < 20) begin
            @(posedge clock_in);
            n++;
        end
        if (n == 20) begin
            n_fail++;
            stop_test();
        end
        rdata = readdata_out;
        write_in <= 1'b0;
        read_in <= 1'b0;
        @(posedge clock_in);
    endtask
    task automatic wr(input logic [3:0] idx, input logic [31:0] d);
        bus(1'b1, idx, d);
    endtask
    task automatic rd(input logic [3:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h0);
        chk(rdata, exp);
    endtask
    // key pulse, then nret retired instructions, then the command write
    task automatic cmd(input logic [7:0] c, input int nret);
        self_program_key_in <= 1'b1;
        @(posedge clock_in);
        self_program_key_in <= 1'b0;
        repeat (nret) begin
            instr_retired_in <= 1'b1;
            @(posedge clock_in);
        end
        instr_retired_in <= 1'b0;
        wr(nvm_pkg::IDX_CMD, {24'h0, c});
    endtask
    task automatic chk_starts(input int f, input int e);
        @(posedge clock_in);
        chk(n_fs, f);
        chk(n_es, e);
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            bus(1'b0, nvm_pkg::IDX_STATUS, 32'h0);
            n++;
        end while (rdata[1:0] !== 2'b00 && n < 50);
        if (n == 50) begin
            n_fail++;
            stop_test();
        end
    endtask
    logic [3:0] zero_idx [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h8};
    initial begin
        {sys_rst_in, read_in, write_in, debug_access_in, self_program_key_in, instr_retired_in} = 6'h20;
        {exec_in_boot_in, buffer_load_in, eeprom_preserve_fuse_in, mem_boot_access_in, sleep_req_in} = 5'h00;
        {sleep_mode_in, byteenable_in, address_in, buffer_load_addr_in, mem_rdata_in} = 44'h0;
        {writedata_in, n_fail, compares, n_fs, n_es} = 160'h0;
        latency = 8'h14;
        repeat (3) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        @(posedge clock_in);
        foreach (zero_idx[i]) rd(zero_idx[i], 32'h0);
        rd(nvm_pkg::IDX_IRQ_FLAGS, 32'h1);
        wr(4'h5, 32'hFF);
        rd(4'h5, 32'h0);
        wr(nvm_pkg::IDX_PROT, 32'hFC);
        rd(nvm_pkg::IDX_PROT, 32'h0);
        wr(nvm_pkg::IDX_CMD, 32'h4);
        rd(nvm_pkg::IDX_CMD, 32'h0);
        cmd(8'h04, 4);
        rd(nvm_pkg::IDX_CMD, 32'h0);
        cmd(8'hFC, 3);
        rd(nvm_pkg::IDX_CMD, 32'h4);
        repeat (8) @(posedge clock_in);
        chk_starts(0, 0);
        wr(nvm_pkg::IDX_ADDR_LO, 32'h1410);
        rd(nvm_pkg::IDX_ADDR_LO, 32'h1410);
        cmd(8'h01, 0);
        chk_starts(0, 1);
        rd(nvm_pkg::IDX_STATUS, 32'h2);
        wr(nvm_pkg::IDX_IRQ_FLAGS, 32'h1);
        rd(nvm_pkg::IDX_IRQ_FLAGS, 32'h0);
        cmd(8'h02, 0);
        rd(nvm_pkg::IDX_CMD, 32'h1);
        sleep_mode_in <= nvm_pkg::SLEEP_POWER_DOWN;
        sleep_req_in <= 1'b1;
        @(posedge clock_in);
        chk_pin(keep_clock_out, 1'b1);
        sleep_req_in <= 1'b0;
        wait_idle();
        rd(nvm_pkg::IDX_IRQ_FLAGS, 32'h1);
        wr(nvm_pkg::IDX_IRQ_EN, 32'h1);
        chk_pin(irq_out, 1'b1);
        sleep_mode_in <= nvm_pkg::SLEEP_IDLE;
        sleep_req_in <= 1'b1;
        @(posedge clock_in);
        chk_pin(nvm_sleep_out, 1'b1);
        chk_pin(wake_out, 1'b1);
        sleep_mode_in <= nvm_pkg::SLEEP_STANDBY;
        @(posedge clock_in);
        chk_pin(wake_out, 1'b0);
        sleep_req_in <= 1'b0;
        wr(nvm_pkg::IDX_IRQ_EN, 32'h0);
        chk_pin(irq_out, 1'b0);
        wr(nvm_pkg::IDX_ADDR_LO, 32'h8300);
        cmd(8'h01, 2);
        chk_starts(1, 1);
        rd(nvm_pkg::IDX_STATUS, 32'h1);
        chk({16'h0, array_addr_out}, 32'h8300);
        wait_idle();
        wr(nvm_pkg::IDX_PROT, 32'h1);
        wr(nvm_pkg::IDX_PROT, 32'h0);
        rd(nvm_pkg::IDX_PROT, 32'h1);
        cmd(8'h02, 0);
        rd(nvm_pkg::IDX_STATUS, 32'h4);
        chk_starts(1, 1);
        latency <= 8'h03;
        eeprom_preserve_fuse_in <= 1'b1;
        cmd(8'h05, 0);
        chk_starts(2, 1);
        wait_idle();
        rd(nvm_pkg::IDX_STATUS, 32'h0);
        eeprom_preserve_fuse_in <= 1'b0;
        cmd(8'h05, 1);
        chk_starts(3, 2);
        wait_idle();
        cmd(8'h06, 1);
        chk_starts(3, 3);
        wait_idle();
        // eeprom byte then flash byte in one buffer: mixed sections
        {buffer_load_in, buffer_load_addr_in} <= 17'h1_1410;
        @(posedge clock_in);
        buffer_load_addr_in <= 16'h0100;
        @(posedge clock_in);
        buffer_load_in <= 1'b0;
        rd(nvm_pkg::IDX_ADDR_LO, 32'h0100);
        cmd(8'h01, 0);
        rd(nvm_pkg::IDX_STATUS, 32'h4);
        cmd(8'h07, 0);
        rd(nvm_pkg::IDX_CMD, 32'h1);
        debug_access_in <= 1'b1;
        wr(nvm_pkg::IDX_DATA_LO, 32'hA5C3);
        wr(nvm_pkg::IDX_DATA_HI, 32'h5A);
        rd(nvm_pkg::IDX_DATA_LO, 32'h5AC3);
        wr(nvm_pkg::IDX_CMD, 32'h7);
        chk_starts(4, 3);
        chk({16'h0, fuse_data_out}, 32'h5AC3);
        debug_access_in <= 1'b0;
        wait_idle();
        wr(nvm_pkg::IDX_PROT, 32'h2);
        rd(nvm_pkg::IDX_PROT, 32'h1);
        exec_in_boot_in <= 1'b1;
        wr(nvm_pkg::IDX_PROT, 32'h2);
        rd(nvm_pkg::IDX_PROT, 32'h3);
        mem_boot_access_in <= 1'b1;
        mem_rdata_in <= 16'h1234;
        repeat (2) @(posedge clock_in);
        chk({16'h0, mem_rdata_out}, 32'h1234);
        exec_in_boot_in <= 1'b0;
        repeat (3) @(posedge clock_in);
        chk({16'h0, mem_rdata_out}, 32'h0);
        wr(nvm_pkg::IDX_PROT, 32'h0);
        rd(nvm_pkg::IDX_PROT, 32'h3);
        stop_test();
    end
endmodule
bind nvm_command_controller nvm_props chk (.*);
